/* File: design/t2c_defs.vh */
// Constants for the timer 2 reload, clock output and enable register block
//
// Behaviour
// - Timer 2 counts only while its run bit is set; otherwise count holds.
// - Counter select 0 counts system clock ticks, 1 counts external pin pulses.
// - Timer mode increments every 12 clocks, or every clock when fast prescale set.
// - Single 16-bit auto-reload mode; count and reload bytes share two addresses.
// - While stopped, a count byte write goes to count and reload byte.
// - While running, count byte writes only go to the reload bytes.
// - Reads of count byte addresses return the live count, never the reload.
// - Overflow sets a hidden request flag and reloads count; reload stays unchanged.
// - Aux bit 0 picks UART1 baud source: 0 timer 1, 1 timer 2 overflow.
// - With timer 2 as baud source, timer 1 prescale bit picks 1T or 12T.
// - Aux bits 7 and 6 pick timer 0 and 1 clock: /12 or /1.
// - Aux bit 5 picks UART1 mode-0 shift rate: clock/12 or clock/2.
// - Aux bit 1 set keeps on-chip auxiliary RAM disabled; clear enables it.
// - Clock-output bit 2 drives timer 2 output pin at half overflow rate.
// - Output frequency is input rate over 65536 minus reload, then halved.
// - Clock-output bit 0 drives timer 0 output pin at half its overflow rate.
// - Clock-output bit 1 drives timer 1 output pin at half its overflow rate.
// - Timer 2 interrupt enable passes overflow requests when 1, blocks when 0.
// - Second enable register also holds timer 4/3, UART4/3, SPI, UART2 enables.
// - Counter mode advances on each falling edge of the external timer 2 pin.
// - Reset clears both timer 2 count bytes to zero.
`ifndef T2C_DEFS_VH
`define T2C_DEFS_VH

// Register indices; byte address is four times the index
`define T2C_IDX_AUX 8'h8e
`define T2C_IDX_CLKO 8'h8f
`define T2C_IDX_IE2 8'haf
`define T2C_IDX_CNT_HI 8'hd6
`define T2C_IDX_CNT_LO 8'hd7
`define T2C_ADDR_W 12

// Auxiliary register fields
`define T2C_AUX_T0_FAST 7
`define T2C_AUX_T1_FAST 6
`define T2C_AUX_M0_FAST 5
`define T2C_AUX_RUN 4
`define T2C_AUX_CSEL 3
`define T2C_AUX_T2_FAST 2
`define T2C_AUX_RAM_DIS 1
`define T2C_AUX_BAUD_SEL 0

// Clock output register fields
`define T2C_CLKO_T2 2
`define T2C_CLKO_T1 1
`define T2C_CLKO_T0 0
`define T2C_CLKO_MASK 8'h7f

// Second enable register fields
`define T2C_IE2_T2 2
`define T2C_IE2_MASK 8'h7f

// Reset values
`define T2C_AUX_RST 8'h01
`define T2C_CLKO_RST 8'h00
`define T2C_IE2_RST 8'h00
`define T2C_CNT_RST 16'h0000
`define T2C_RLD_RST 16'h0000

// Prescale and mode-0 divisors, as last count value
`define T2C_SLOW_LAST 4'hb
`define T2C_M0_FAST_LAST 4'h1

`endif

/* File: design/t2c_timer2.v */
// Timer 2 auto-reload counter, clock outputs and enable registers on APB
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/100ps
`include "t2c_defs.vh"

module t2c_timer2 (
    // APB clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`T2C_ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // External timer 2 pulse pin (asynchronous)
    input wire timer2_pin,
    // Timer 0 and 1 overflow pulses from their counters
    input wire timer0_overflow,
    input wire timer1_overflow,
    // Interrupt acknowledge for timer 2 from the processor core
    input wire timer2_irq_ack,
    // Timer 2 interrupt request towards the processor
    output reg timer2_irq,
    // Timer 2 overflow pulse
    output reg timer2_overflow,
    // Clock output pins with output enables
    output reg timer2_clk_out,
    output reg timer2_clk_out_oe,
    output reg timer1_clk_out,
    output reg timer1_clk_out_oe,
    output reg timer0_clk_out,
    output reg timer0_clk_out_oe,
    // UART1 baud source and prescale
    output reg uart1_baud_tick,
    output reg uart_baud_fast,
    output reg uart1_mode0_tick,
    // Timer 0 and 1 prescale selects and RAM control
    output reg timer0_fast_prescale,
    output reg timer1_fast_prescale,
    output reg aux_ram_disable,
    // Enable bits for other interrupt sources, plus the master clock output divider select
    output reg ext_int4_enable,
    output reg ext_int3_enable,
    output reg ext_int2_enable,
    output reg master_clock_out_divider_sel,
    output reg timer4_irq_enable,
    output reg timer3_irq_enable,
    output reg serial4_irq_enable,
    output reg serial3_irq_enable,
    output reg spi_irq_enable,
    output reg serial2_irq_enable
);

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------

    // Maps a byte address to a one-hot select of the five registers
    function [4:0] t2c_decode;
        input [`T2C_ADDR_W-1:0] addr;
        begin
            t2c_decode = 5'h00;
            if (addr[1:0] == 2'h0) begin
                case (addr[`T2C_ADDR_W-1:2])
                    {2'h0, `T2C_IDX_AUX}: t2c_decode = 5'h01;
                    {2'h0, `T2C_IDX_CLKO}: t2c_decode = 5'h02;
                    {2'h0, `T2C_IDX_IE2}: t2c_decode = 5'h04;
                    {2'h0, `T2C_IDX_CNT_HI}: t2c_decode = 5'h08;
                    {2'h0, `T2C_IDX_CNT_LO}: t2c_decode = 5'h10;
                    default: t2c_decode = 5'h00;
                endcase
            end
        end
    endfunction

    wire [4:0] sel_w;
    wire acc_w;
    wire wr_w;
    wire lane0_w;
    wire pslverr_nxt_w;

    assign sel_w = t2c_decode(paddr);
    // The access completes on the second access cycle, when pready is high
    assign acc_w = psel & penable & pready;
    assign wr_w = acc_w & pwrite & ~pslverr_nxt_w;
    // Data sits in byte lane 0; a write without that lane changes nothing
    assign lane0_w = pstrb[0];
    assign pslverr_nxt_w = (sel_w == 5'h00);

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------

    reg [7:0] aux_r;
    reg [7:0] clko_r;
    reg [7:0] ie2_r;

    // Software writes to the three control registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aux_r <= `T2C_AUX_RST;
            clko_r <= `T2C_CLKO_RST;
            ie2_r <= `T2C_IE2_RST;
        end else if (wr_w && lane0_w) begin
            if (sel_w[0]) begin
                aux_r <= pwdata[7:0];
            end
            if (sel_w[1]) begin
                clko_r <= pwdata[7:0] & `T2C_CLKO_MASK;
            end
            if (sel_w[2]) begin
                ie2_r <= pwdata[7:0] & `T2C_IE2_MASK;
            end
        end
    end

    wire run_w;
    wire csel_w;
    wire t2_fast_w;
    assign run_w = aux_r[`T2C_AUX_RUN];
    assign csel_w = aux_r[`T2C_AUX_CSEL];
    assign t2_fast_w = aux_r[`T2C_AUX_T2_FAST];

    // ----------------------------------------------------------------
    // External pin synchroniser and falling edge
    // ----------------------------------------------------------------

    reg pin_meta_r;
    reg pin_sync_r;
    reg pin_prev_r;

    // Two flops before use; the third only feeds the edge detector
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta_r <= 1'b1;
            pin_sync_r <= 1'b1;
            pin_prev_r <= 1'b1;
        end else begin
            pin_meta_r <= timer2_pin;
            pin_sync_r <= pin_meta_r;
            pin_prev_r <= pin_sync_r;
        end
    end

    wire pin_fall_w;
    assign pin_fall_w = pin_prev_r & ~pin_sync_r;

    // ----------------------------------------------------------------
    // Prescaler and count tick
    // ----------------------------------------------------------------

    reg [3:0] presc_r;
    reg [3:0] presc_nxt;
    reg tick_nxt;

    // Prescaler runs only in timer mode while the timer runs, so a
    // restart always begins a full twelve-clock period
    always @* begin
        presc_nxt = 4'h0;
        tick_nxt = 1'b0;
        if (run_w) begin
            if (csel_w) begin
                tick_nxt = pin_fall_w;
            end else if (t2_fast_w) begin
                tick_nxt = 1'b1;
            end else if (presc_r == `T2C_SLOW_LAST) begin
                tick_nxt = 1'b1;
            end else begin
                presc_nxt = presc_r + 4'h1;
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_r <= 4'h0;
        end else begin
            presc_r <= presc_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Count and hidden reload registers
    // ----------------------------------------------------------------

    reg [15:0] count_r;
    reg [15:0] count_nxt;
    reg [15:0] reload_r;
    reg [15:0] reload_nxt;
    reg ovf_nxt;

    always @* begin
        count_nxt = count_r;
        reload_nxt = reload_r;
        ovf_nxt = 1'b0;
        if (tick_nxt) begin
            if (count_r == 16'hffff) begin
                count_nxt = reload_r;
                ovf_nxt = 1'b1;
            end else begin
                count_nxt = count_r + 16'h0001;
            end
        end
        if (wr_w && lane0_w && sel_w[3]) begin
            reload_nxt[15:8] = pwdata[7:0];
            if (!run_w) begin
                count_nxt[15:8] = pwdata[7:0];
            end
        end
        if (wr_w && lane0_w && sel_w[4]) begin
            reload_nxt[7:0] = pwdata[7:0];
            if (!run_w) begin
                count_nxt[7:0] = pwdata[7:0];
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_r <= `T2C_CNT_RST;
            reload_r <= `T2C_RLD_RST;
            timer2_overflow <= 1'b0;
        end else begin
            count_r <= count_nxt;
            reload_r <= reload_nxt;
            timer2_overflow <= ovf_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Hidden interrupt request flag
    // ----------------------------------------------------------------

    reg irq_flag_r;
    reg irq_flag_nxt;

    // A new overflow wins over an acknowledge in the same cycle
    always @* begin
        irq_flag_nxt = irq_flag_r;
        if (timer2_irq_ack) begin
            irq_flag_nxt = 1'b0;
        end
        if (ovf_nxt) begin
            irq_flag_nxt = 1'b1;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_flag_r <= 1'b0;
            timer2_irq <= 1'b0;
        end else begin
            irq_flag_r <= irq_flag_nxt;
            timer2_irq <= irq_flag_nxt & ie2_r[`T2C_IE2_T2];
        end
    end

    // ----------------------------------------------------------------
    // Programmable clock outputs
    // ----------------------------------------------------------------

    wire [2:0] ovf_src_w;
    wire [2:0] clk_en_w;
    reg [2:0] clk_out_r;
    assign ovf_src_w = {ovf_nxt, timer1_overflow, timer0_overflow};
    assign clk_en_w = {clko_r[`T2C_CLKO_T2], clko_r[`T2C_CLKO_T1], clko_r[`T2C_CLKO_T0]};

    // One toggle flop per timer; disabled outputs rest low so the
    // first toggle after enabling always rises
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_clko
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    clk_out_r[gi] <= 1'b0;
                end else if (!clk_en_w[gi]) begin
                    clk_out_r[gi] <= 1'b0;
                end else if (ovf_src_w[gi]) begin
                    clk_out_r[gi] <= ~clk_out_r[gi];
                end
            end
        end
    endgenerate

    // Pin outputs registered from the toggles and enables
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer2_clk_out <= 1'b0;
            timer2_clk_out_oe <= 1'b0;
            timer1_clk_out <= 1'b0;
            timer1_clk_out_oe <= 1'b0;
            timer0_clk_out <= 1'b0;
            timer0_clk_out_oe <= 1'b0;
        end else begin
            timer2_clk_out <= clk_out_r[2];
            timer2_clk_out_oe <= clk_en_w[2];
            timer1_clk_out <= clk_out_r[1];
            timer1_clk_out_oe <= clk_en_w[1];
            timer0_clk_out <= clk_out_r[0];
            timer0_clk_out_oe <= clk_en_w[0];
        end
    end

    // ----------------------------------------------------------------
    // UART1 baud source and mode-0 shift tick
    // ----------------------------------------------------------------

    reg [3:0] m0_cnt_r;
    reg [3:0] m0_cnt_nxt;
    reg m0_tick_nxt;
    wire [3:0] m0_last_w;
    assign m0_last_w = aux_r[`T2C_AUX_M0_FAST] ? `T2C_M0_FAST_LAST : `T2C_SLOW_LAST;

    always @* begin
        m0_tick_nxt = 1'b0;
        m0_cnt_nxt = m0_cnt_r + 4'h1;
        if (m0_cnt_r >= m0_last_w) begin
            m0_tick_nxt = 1'b1;
            m0_cnt_nxt = 4'h0;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            m0_cnt_r <= 4'h0;
            uart1_mode0_tick <= 1'b0;
            uart1_baud_tick <= 1'b0;
            uart_baud_fast <= 1'b0;
        end else begin
            m0_cnt_r <= m0_cnt_nxt;
            uart1_mode0_tick <= m0_tick_nxt;
            uart1_baud_tick <= aux_r[`T2C_AUX_BAUD_SEL] ? ovf_nxt : timer1_overflow;
            uart_baud_fast <= aux_r[`T2C_AUX_T1_FAST];
        end
    end

    // ----------------------------------------------------------------
    // Static control outputs
    // ----------------------------------------------------------------

    // Registered copies so every output leaves a flop
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer0_fast_prescale <= 1'b0;
            timer1_fast_prescale <= 1'b0;
            aux_ram_disable <= 1'b0;
            ext_int4_enable <= 1'b0;
            ext_int3_enable <= 1'b0;
            ext_int2_enable <= 1'b0;
            master_clock_out_divider_sel <= 1'b0;
            timer4_irq_enable <= 1'b0;
            timer3_irq_enable <= 1'b0;
            serial4_irq_enable <= 1'b0;
            serial3_irq_enable <= 1'b0;
            spi_irq_enable <= 1'b0;
            serial2_irq_enable <= 1'b0;
        end else begin
            timer0_fast_prescale <= aux_r[`T2C_AUX_T0_FAST];
            timer1_fast_prescale <= aux_r[`T2C_AUX_T1_FAST];
            aux_ram_disable <= aux_r[`T2C_AUX_RAM_DIS];
            ext_int4_enable <= clko_r[6];
            ext_int3_enable <= clko_r[5];
            ext_int2_enable <= clko_r[4];
            master_clock_out_divider_sel <= clko_r[3];
            timer4_irq_enable <= ie2_r[6];
            timer3_irq_enable <= ie2_r[5];
            serial4_irq_enable <= ie2_r[4];
            serial3_irq_enable <= ie2_r[3];
            spi_irq_enable <= ie2_r[1];
            serial2_irq_enable <= ie2_r[0];
        end
    end

    // ----------------------------------------------------------------
    // APB answer
    // ----------------------------------------------------------------

    reg [7:0] rd_byte;

    always @* begin
        case (sel_w)
            5'h01: rd_byte = aux_r;
            5'h02: rd_byte = clko_r;
            5'h04: rd_byte = ie2_r;
            5'h08: rd_byte = count_r[15:8];
            5'h10: rd_byte = count_r[7:0];
            default: rd_byte = 8'h00;
        endcase
    end

    // One wait state: pready rises on the second access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & pslverr_nxt_w;
            if (psel && penable && !pready && !pwrite) begin
                prdata <= {24'h000000, rd_byte};
            end
        end
    end

endmodule

/* File: verif/t2c_timer2_monitor.sv */
// Port-level assertion checker for the timer 2 block
`timescale 1ns/100ps
`include "t2c_defs.vh"
module t2c_monitor (
    // Clock, reset and bus
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`T2C_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    input wire logic pslverr,
    // Timer events and interrupt
    input wire logic timer0_overflow,
    input wire logic timer1_overflow,
    input wire logic timer2_irq_ack,
    input wire logic timer2_irq,
    input wire logic timer2_overflow,
    input wire logic uart1_baud_tick,
    // Clock outputs
    input wire logic timer2_clk_out,
    input wire logic timer2_clk_out_oe,
    input wire logic timer1_clk_out,
    input wire logic timer1_clk_out_oe,
    input wire logic timer0_clk_out,
    input wire logic timer0_clk_out_oe,
    // Register fields
    input wire logic timer0_fast_prescale,
    input wire logic timer1_fast_prescale,
    input wire logic aux_ram_disable,
    input wire logic timer4_irq_enable,
    input wire logic timer3_irq_enable,
    input wire logic serial4_irq_enable,
    input wire logic serial3_irq_enable,
    input wire logic spi_irq_enable,
    input wire logic serial2_irq_enable
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Completed writes that the block accepts
    wire wr_ok = psel && penable && pready && pwrite && pstrb[0] && !pslverr;
    wire wr_aux = wr_ok && paddr == 12'h238;
    wire wr_ie2 = wr_ok && paddr == 12'h2bc;

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    property p_aux_fields;
        wr_aux |-> ##2 {timer0_fast_prescale, timer1_fast_prescale, aux_ram_disable}
            == {$past(pwdata[7], 2), $past(pwdata[6], 2), $past(pwdata[1], 2)};
    endproperty
    a_aux_fields: assert property (p_aux_fields) else $error("aux fields wrong");
    property p_ie2_fields;
        wr_ie2 |-> ##2 {timer4_irq_enable, timer3_irq_enable, serial4_irq_enable,
            serial3_irq_enable, spi_irq_enable, serial2_irq_enable}
            == {$past(pwdata[6:3], 2), $past(pwdata[1:0], 2)};
    endproperty
    a_ie2_fields: assert property (p_ie2_fields) else $error("enable bits wrong");
    property p_irq_cause;
        $rose(timer2_irq) |-> timer2_overflow || $past(wr_ie2) || $past(wr_ie2, 2);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");
    property p_irq_ack;
        timer2_irq_ack |=> !timer2_irq || timer2_overflow;
    endproperty
    a_irq_ack: assert property (p_irq_ack) else $error("irq kept after ack");
    property p_t0_toggle;
        timer0_overflow && timer0_clk_out_oe |-> ##[1:2] $changed(timer0_clk_out);
    endproperty
    a_t0_toggle: assert property (p_t0_toggle) else $error("t0 out no toggle");
    property p_t1_toggle;
        timer1_overflow && timer1_clk_out_oe |-> ##[1:2] $changed(timer1_clk_out);
    endproperty
    a_t1_toggle: assert property (p_t1_toggle) else $error("t1 out no toggle");
    property p_t2_toggle;
        timer2_overflow && timer2_clk_out_oe |-> ##[0:2] $changed(timer2_clk_out);
    endproperty
    a_t2_toggle: assert property (p_t2_toggle) else $error("t2 out no toggle");
    // A disabled output settles low, allowing the output register lag
    property p_t2_idle;
        !timer2_clk_out_oe [*3] |-> !timer2_clk_out;
    endproperty
    a_t2_idle: assert property (p_t2_idle) else $error("t2 out not idle");
    property p_baud_src;
        uart1_baud_tick |-> $past(timer1_overflow) || timer2_overflow || $past(timer2_overflow);
    endproperty
    a_baud_src: assert property (p_baud_src) else $error("baud tick no source");
    property p_ready;
        psel && !penable |=> !pready ##1 pready;
    endproperty
    a_ready: assert property (p_ready) else $error("ready timing wrong");
    property p_slverr;
        psel && penable && pready && paddr[1:0] != 2'b00 |-> pslverr;
    endproperty
    a_slverr: assert property (p_slverr) else $error("unaligned not refused");

    // Main scenarios reached
    c_irq: cover property ($rose(timer2_irq));
    c_t2_out: cover property (timer2_overflow && timer2_clk_out_oe);
    c_err: cover property (psel && penable && pready && pslverr);
endmodule

bind t2c_timer2 t2c_monitor t2c_monitor_inst (.*);

/* File: verif/tb.sv */
// Self-checking bench for the timer 2 block
`timescale 1ns/100ps
`include "t2c_defs.vh"
module tb;
    // ----------------------------------------
    // Signals and bookkeeping
    // ----------------------------------------
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, timer2_pin;
    logic [`T2C_ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic timer0_overflow, timer1_overflow, timer2_irq_ack, timer2_irq, timer2_overflow;
    logic timer2_clk_out, timer2_clk_out_oe, timer1_clk_out, timer1_clk_out_oe;
    logic timer0_clk_out, timer0_clk_out_oe, uart1_baud_tick, uart_baud_fast;
    logic uart1_mode0_tick, timer0_fast_prescale, timer1_fast_prescale, aux_ram_disable;
    logic ext_int4_enable, ext_int3_enable, ext_int2_enable, master_clock_out_divider_sel;
    logic timer4_irq_enable, timer3_irq_enable, serial4_irq_enable, serial3_irq_enable;
    logic spi_irq_enable, serial2_irq_enable;
    localparam logic [11:0] A_AUX = 12'h238;
    localparam logic [11:0] A_CLKO = 12'h23c;
    localparam logic [11:0] A_IE2 = 12'h2bc;
    localparam logic [11:0] A_HI = 12'h358;
    localparam logic [11:0] A_LO = 12'h35c;
    int checks = 0, num_errors = 0, cyc = 0, t_done, t1, n, b0;
    int gap = 0, last_ovf = 0, n_ovf = 0, m0_gap = 0, last_m0 = 0, n_baud = 0;
    logic [33:0] expq[$];
    logic [33:0] e;
    logic [15:0] ex;
    logic [7:0] r;

    t2c_timer2 t2c_timer2_inst (.*);

    initial begin
        pclk = 0;
        forever #50 pclk = ~pclk;
    end

    task automatic conclude;
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask

    // One bus transfer; e holds {is_read, expected error, expected data}
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                       input logic [33:0] ee);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        expq.push_back(ee);
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        t_done = cyc;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d, 34'h0);
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] d);
        apb(1'b0, a, 8'h00, {2'b10, 24'h0, d});
    endtask

    task automatic wait_ovf(input int k);
        k = n_ovf + k;
        while (n_ovf < k) @(posedge pclk);
    endtask

    // ----------------------------------------
    // Output watcher, event timing and timeout
    // ----------------------------------------
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (psel && penable && pready === 1'b1 && expq.size() > 0) begin
            e = expq.pop_front();
            chk(pslverr === e[32], "error response");
            if (e[33])
                chk(prdata === e[31:0], "read data");
        end
        if (timer2_overflow === 1'b1) begin
            gap <= cyc - last_ovf;
            last_ovf <= cyc;
            n_ovf <= n_ovf + 1;
        end
        if (uart1_mode0_tick === 1'b1) begin
            m0_gap <= cyc - last_m0;
            last_m0 <= cyc;
        end
        if (uart1_baud_tick === 1'b1)
            n_baud <= n_baud + 1;
        // Run needs about 600 cycles; a hang ends here
        if (cyc == 6000) begin
            num_errors++;
            conclude();
        end
    end

    initial begin
        {presetn, psel, penable, pwrite, timer0_overflow, timer1_overflow} = 6'h0;
        {timer2_irq_ack, paddr, pwdata} = '0;
        pstrb = 4'h1;
        timer2_pin = 1'b1;
        void'($urandom(32'hccbb5c17));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd(A_AUX, 8'h01);
        rd(A_HI, 8'h00);
        rd(A_LO, 8'h00);
        r = 8'($urandom);
        wr(A_IE2, r & 8'hfb);
        rd(A_IE2, r & 8'h7b);
        r = 8'($urandom);
        wr(A_CLKO, r & 8'hf8);
        rd(A_CLKO, r & 8'h78);
        chk({ext_int4_enable, ext_int3_enable, ext_int2_enable,
             master_clock_out_divider_sel} === r[6:3], "clko enables");
        // Refused places and a write with its byte strobe off
        apb(1'b1, 12'h100, 8'hff, {2'b01, 32'h0});
        apb(1'b0, 12'h239, 8'h00, {2'b01, 32'h0});
        wr(A_AUX, 8'he2);
        pstrb <= 4'h0;
        wr(A_AUX, 8'h5a);
        pstrb <= 4'h1;
        rd(A_AUX, 8'he2);
        chk(uart_baud_fast === 1'b1, "baud prescale fast");
        repeat (10) @(posedge pclk);
        chk(m0_gap == 2, "mode0 fast rate");
        wr(A_AUX, 8'h00);
        repeat (30) @(posedge pclk);
        chk(m0_gap == 12, "mode0 slow rate");
        chk(uart_baud_fast === 1'b0, "baud prescale slow");
        // Stopped writes land in count and reload alike
        wr(A_HI, 8'h12);
        wr(A_LO, 8'h34);
        rd(A_HI, 8'h12);
        rd(A_LO, 8'h34);
        wr(A_AUX, 8'h14);
        t1 = t_done;
        repeat (20) @(posedge pclk);
        wr(A_AUX, 8'h04);
        ex = 16'h1234 + 16'(t_done - t1);
        repeat (15) @(posedge pclk);
        rd(A_HI, ex[15:8]);
        rd(A_LO, ex[7:0]);
        // Span of 127 clocks keeps the /12 result clear of tick alignment
        wr(A_AUX, 8'h10);
        t1 = t_done;
        repeat (123) @(posedge pclk);
        wr(A_AUX, 8'h00);
        ex = ex + 16'((t_done - t1) / 12);
        rd(A_HI, ex[15:8]);
        rd(A_LO, ex[7:0]);
        // Counter mode: pin falling edges only, slow enough to expose clock ticks
        wr(A_AUX, 8'h18);
        n = $urandom_range(8, 3);
        repeat (n) begin
            timer2_pin <= 1'b0;
            repeat (6) @(posedge pclk);
            timer2_pin <= 1'b1;
            repeat (6) @(posedge pclk);
        end
        wr(A_AUX, 8'h08);
        ex = ex + 16'(n);
        rd(A_HI, ex[15:8]);
        rd(A_LO, ex[7:0]);
        // Reload 0xfff0, clock output on, interrupt masked
        wr(A_HI, 8'hff);
        wr(A_LO, 8'hf0);
        wr(A_CLKO, 8'h04);
        wr(A_AUX, 8'h14);
        wait_ovf(3);
        chk(gap == 16, "reload period");
        chk(timer2_irq === 1'b0, "masked irq");
        chk(timer2_clk_out_oe === 1'b1, "clock out enable");
        wr(A_LO, 8'hfa);
        wait_ovf(3);
        chk(gap == 6, "new reload period");
        wr(A_AUX, 8'h15);
        wait_ovf(1);
        b0 = n_baud;
        wait_ovf(4);
        chk(n_baud - b0 == 4, "baud from timer 2");
        wr(A_AUX, 8'h04);
        rd(A_HI, 8'hff);
        wr(A_IE2, 8'h04);
        repeat (2) @(posedge pclk);
        chk(timer2_irq === 1'b1, "pending irq passed");
        timer2_irq_ack <= 1'b1;
        @(posedge pclk);
        timer2_irq_ack <= 1'b0;
        repeat (2) @(posedge pclk);
        chk(timer2_irq === 1'b0, "irq after ack");
        // Timer 0 and 1 outputs; three toggles from low end high
        wr(A_CLKO, 8'h03);
        b0 = n_baud;
        repeat (3) begin
            timer0_overflow <= 1'b1;
            timer1_overflow <= 1'b1;
            @(posedge pclk);
            timer0_overflow <= 1'b0;
            timer1_overflow <= 1'b0;
            repeat (4) @(posedge pclk);
        end
        chk(timer0_clk_out === 1'b1, "t0 clock out");
        chk(timer1_clk_out === 1'b1, "t1 clock out");
        chk(n_baud - b0 == 3, "baud from timer 1");
        conclude();
    end
endmodule
